// file: src/rta_pkg.sv
// Constants for the time-count trim and alarm compare block
package rta_pkg;
  // ****************************************
  // Clock rates and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  localparam int unsigned OSC_HALF_DIV = (CLK_HZ + OSC_HZ) / (2 * OSC_HZ);
  localparam logic [15:0] NOMINAL_COUNTS = 16'h8000;
  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [5:0] IDX_TRIM = 6'h07;
  localparam logic [5:0] IDX_WMIN = 6'h08;
  localparam logic [5:0] IDX_WHOUR = 6'h09;
  localparam logic [5:0] IDX_WDAYS = 6'h0A;
  localparam logic [5:0] IDX_DMIN = 6'h0B;
  localparam logic [5:0] IDX_DHOUR = 6'h0C;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
  // ****************************************
  // Field layout
  // ****************************************
  localparam int unsigned TRIM_PERIOD_SELECT = 7;
  localparam int unsigned TRIM_SIGN = 6;
  localparam logic [7:0] MINUTE_MASK = 8'h7F;
  localparam logic [7:0] HOUR_MASK = 8'h3F;
  localparam logic [7:0] DAYS_MASK = 8'h7F;
  localparam logic [7:0] IRQ_MASK_BITS = 8'h03;
  localparam int unsigned IRQ_WEEKLY = 0;
  localparam int unsigned IRQ_DAILY = 1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  // ****************************************
  // Seconds values at which trimming applies
  // ****************************************
  localparam logic [6:0] SEC_00 = 7'h00;
  localparam logic [6:0] SEC_20 = 7'h20;
  localparam logic [6:0] SEC_40 = 7'h40;
endpackage

// file: src/rta_trim_alarm.sv
// Time-count trim, weekly and daily alarm compare, APB register slave
// Summary of operation
// RULE1: Period select zero: trim applies when seconds become 00, 20 or 40.
// RULE2: Period select one: trim applies only when seconds become 00.
// RULE3: At a trim instant the counts per second follow the trim register.
// RULE4: A trim write during a trim instant's second cancels that adjustment.
// RULE5: Sign zero: second lengthens by twice (low six bits minus one).
// RULE6: Sign one: second shortens by twice the negative value's magnitude.
// RULE7: Bits five to one all zero keep the nominal 32768 counts.
// RULE8: The 32.768 kHz clock output never changes with the trim.
// RULE9: Weekly minute holds BCD in bits 6..0; bit 7 reads zero.
// RULE10: Weekly hour bit 5 is pm flag or twenty-hours digit.
// RULE11: Daily hour bit 5 is pm flag or twenty-hours digit.
// RULE12: In 12-hour mode code 12 is midnight and 32 is noon.
// RULE13: Day mask bit n selects weekday counter value n, 0 to 6.
// RULE14: An all-zero day mask never raises the weekly alarm.
// RULE15: Daily minute holds BCD in bits 6..0; bit 7 reads zero.
// RULE16: Host programs only existing times into the alarm registers.
// RULE17: Trim register: period select bit 7, signed value 6..0, resets zero.
// RULE18: Alarms fire on minute and hour match, weekly also on day mask.
// RULE19: Unused upper alarm bits ignored on write, read as zero.
`timescale 1ns/1ps
module rta_trim_alarm #(
  parameter int unsigned HALF_DIV = rta_pkg::OSC_HALF_DIV
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic PREADY_O,
  output logic [31:0] PRDATA_O,
  output logic PSLVERR_O,
  input wire logic [6:0] SECONDS_I,
  input wire logic [6:0] MINUTE_I,
  input wire logic [5:0] HOUR_I,
  input wire logic [2:0] WEEKDAY_I,
  output logic SEC_TICK_O,
  output logic CLK32K_O,
  output logic ALARM_W_O,
  output logic ALARM_D_O,
  output logic IRQ_O
);
  import rta_pkg::*;

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic is_mapped(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    is_mapped = (addr[1:0] == 2'b00) &&
      ((idx == IDX_TRIM) || (idx == IDX_WMIN) || (idx == IDX_WHOUR) ||
       (idx == IDX_WDAYS) || (idx == IDX_DMIN) || (idx == IDX_DHOUR) ||
       (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK));
  endfunction

  function automatic logic is_instant(input logic [7:0] trim, input logic [6:0] sec);
    logic hit;
    hit = (sec == SEC_00);
    if (!trim[TRIM_PERIOD_SELECT]) begin
      hit = hit || (sec == SEC_20) || (sec == SEC_40); // RULE1
    end
    is_instant = hit; // RULE2
  endfunction

  // Length of an adjusted second in oscillator counts
  function automatic logic [15:0] trim_len(input logic [7:0] trim);
    logic [15:0] val;
    val = {{9{trim[TRIM_SIGN]}}, trim[6:0]};
    if (trim[5:1] == 5'b0_0000) begin
      trim_len = NOMINAL_COUNTS; // RULE7
    end else if (!trim[TRIM_SIGN]) begin
      trim_len = 16'(NOMINAL_COUNTS + ((val - 16'h0001) << 1)); // RULE5
    end else begin
      trim_len = 16'(NOMINAL_COUNTS + (val << 1)); // RULE6
    end
  endfunction

  // Writable bits per register; writes and reads share one set of masks
  function automatic logic [7:0] field_mask(input logic [5:0] sel);
    field_mask = 8'h00;
    case (sel)
      IDX_TRIM: begin
        field_mask = 8'hFF; // RULE17
      end
      IDX_WMIN, IDX_DMIN: begin
        field_mask = MINUTE_MASK; // RULE9
      end
      IDX_WHOUR, IDX_DHOUR: begin
        field_mask = HOUR_MASK; // RULE19
      end
      IDX_WDAYS: begin
        field_mask = DAYS_MASK; // RULE19
      end
      IDX_IRQ_MASK: begin
        field_mask = IRQ_MASK_BITS;
      end
      default: begin
        field_mask = 8'h00;
      end
    endcase
  endfunction

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] trim_q;
  logic [7:0] wmin_q;
  logic [7:0] whour_q;
  logic [7:0] wdays_q;
  logic [7:0] dmin_q;
  logic [7:0] dhour_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_status_d;
  logic [7:0] irq_mask_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [7:0] rd_val;
  logic wr_en;
  logic rd_en;
  logic [5:0] idx;
  logic trim_wr;

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state: pready rises one cycle into the access phase, so read
  // data and the error flag are always registered before they are seen.
  assign idx = PADDR_I[7:2];
  assign wr_en = PSEL_I && PENABLE_I && pready_q && PWRITE_I && PSTRB_I[0] && is_mapped(PADDR_I);
  assign rd_en = PSEL_I && PENABLE_I && pready_q && !PWRITE_I && is_mapped(PADDR_I);
  assign trim_wr = wr_en && (idx == IDX_TRIM);

  always_comb begin
    rd_val = 8'h00;
    case (idx)
      IDX_TRIM: begin
        rd_val = trim_q;
      end
      IDX_WMIN: begin
        rd_val = wmin_q & MINUTE_MASK; // RULE9
      end
      IDX_WHOUR: begin
        rd_val = whour_q & HOUR_MASK; // RULE10
      end
      IDX_WDAYS: begin
        rd_val = wdays_q & DAYS_MASK; // RULE19
      end
      IDX_DMIN: begin
        rd_val = dmin_q & MINUTE_MASK; // RULE15
      end
      IDX_DHOUR: begin
        rd_val = dhour_q & HOUR_MASK; // RULE11
      end
      IDX_IRQ_STATUS: begin
        rd_val = irq_status_q;
      end
      IDX_IRQ_MASK: begin
        rd_val = irq_mask_q;
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (PSEL_I && PENABLE_I && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !is_mapped(PADDR_I);
      prdata_q <= {24'h00_0000, (is_mapped(PADDR_I) ? rd_val : 8'h00)};
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      trim_q <= TRIM_RESET; // RULE17
    end else if (trim_wr) begin
      trim_q <= PWDATA_I[7:0]; // RULE17
    end
  end

  // Alarm fields have no meaningful power-up value; zero keeps simulation clean
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      wmin_q <= ALARM_RESET;
      whour_q <= ALARM_RESET;
      wdays_q <= ALARM_RESET;
      dmin_q <= ALARM_RESET;
      dhour_q <= ALARM_RESET;
    end else if (wr_en) begin
      case (idx)
        IDX_WMIN: begin
          wmin_q <= PWDATA_I[7:0] & field_mask(idx); // RULE9
        end
        IDX_WHOUR: begin
          whour_q <= PWDATA_I[7:0] & field_mask(idx); // RULE10
        end
        IDX_WDAYS: begin
          wdays_q <= PWDATA_I[7:0] & field_mask(idx); // RULE19
        end
        IDX_DMIN: begin
          dmin_q <= PWDATA_I[7:0] & field_mask(idx); // RULE15
        end
        IDX_DHOUR: begin
          dhour_q <= PWDATA_I[7:0] & field_mask(idx); // RULE11
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      irq_mask_q <= IRQ_RESET;
    end else if (wr_en && (idx == IDX_IRQ_MASK)) begin
      irq_mask_q <= PWDATA_I[7:0] & field_mask(idx);
    end
  end

  // ****************************************
  // Oscillator rate divider and clock output
  // ****************************************
  // The output square wave is fed only by this divider, so trimming
  // moves the second boundary but never the output frequency.
  logic [15:0] div_q;
  logic clk32k_q;
  logic osc_tick;

  assign osc_tick = (div_q == 16'(HALF_DIV - 1)) && clk32k_q;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      div_q <= 16'h0000;
      clk32k_q <= 1'b0;
    end else if (div_q == 16'(HALF_DIV - 1)) begin
      div_q <= 16'h0000;
      clk32k_q <= !clk32k_q; // RULE8
    end else begin
      div_q <= 16'(div_q + 16'h0001);
    end
  end

  // ****************************************
  // Second length counter with trim
  // ****************************************
  logic [15:0] cnt_q;
  logic [15:0] len_q;
  logic adj_q;
  logic tick_q;
  logic start_q;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (osc_tick && (cnt_q == 16'(len_q - 16'h0001))) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= osc_tick ? 16'(cnt_q + 16'h0001) : cnt_q;
      tick_q <= 1'b0;
    end
  end

  // The time counter moves on the tick, so the new seconds value is
  // judged one cycle later when it has settled.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      start_q <= 1'b0;
    end else begin
      start_q <= tick_q;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      len_q <= NOMINAL_COUNTS;
      adj_q <= 1'b0;
    end else if (start_q) begin
      if (is_instant(trim_q, SECONDS_I) && !trim_wr) begin
        len_q <= trim_len(trim_q); // RULE3
        adj_q <= 1'b1;
      end else begin
        len_q <= NOMINAL_COUNTS;
        adj_q <= 1'b0;
      end
    end else if (trim_wr && adj_q) begin
      len_q <= NOMINAL_COUNTS; // RULE4
      adj_q <= 1'b0;
    end
  end

  // ****************************************
  // Alarm compare
  // ****************************************
  // Hour codes compare as stored, so 12-hour codes 12 and 32 match the
  // counter directly; impossible settings simply never match.
  logic w_match;
  logic d_match;
  logic alarm_w_q;
  logic alarm_d_q;
  logic [6:0] day_sel;

  assign day_sel = (WEEKDAY_I == 3'b111) ? 7'h00 : 7'(7'h01 << WEEKDAY_I); // RULE13
  assign w_match = (MINUTE_I == wmin_q[6:0]) && (HOUR_I == whour_q[5:0]) && // RULE12
    ((day_sel & wdays_q[6:0]) != 7'h00); // RULE14
  assign d_match = (MINUTE_I == dmin_q[6:0]) && (HOUR_I == dhour_q[5:0]); // RULE18

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      alarm_w_q <= 1'b0;
      alarm_d_q <= 1'b0;
    end else begin
      alarm_w_q <= w_match; // RULE18
      alarm_d_q <= d_match; // RULE18
    end
  end

  // ****************************************
  // Interrupt status, mask and output
  // ****************************************
  // Events are match rising edges; a new event in the cycle of the
  // clearing read survives the clear.
  always_comb begin
    irq_status_d = irq_status_q;
    if (rd_en && (idx == IDX_IRQ_STATUS)) begin
      irq_status_d = 8'h00;
    end
    if (w_match && !alarm_w_q) begin
      irq_status_d[IRQ_WEEKLY] = 1'b1;
    end
    if (d_match && !alarm_d_q) begin
      irq_status_d[IRQ_DAILY] = 1'b1;
    end
  end

  logic irq_q;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      irq_status_q <= IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_q <= (irq_status_d & irq_mask_q) != 8'h00;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign PREADY_O = pready_q;
  assign PRDATA_O = prdata_q;
  assign PSLVERR_O = pslverr_q;
  assign SEC_TICK_O = tick_q;
  assign CLK32K_O = clk32k_q;
  assign ALARM_W_O = alarm_w_q;
  assign ALARM_D_O = alarm_d_q;
  assign IRQ_O = irq_q;
endmodule

// file: tb/rta_trim_alarm_monitor.sv
// Port-level checker for the trim and alarm register block
`timescale 1ns/1ps
module rta_trim_alarm_monitor #(
  parameter int unsigned HALF_DIV = rta_pkg::OSC_HALF_DIV
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic PREADY_O,
  input wire logic [31:0] PRDATA_O,
  input wire logic PSLVERR_O,
  input wire logic [6:0] SECONDS_I,
  input wire logic [6:0] MINUTE_I,
  input wire logic [5:0] HOUR_I,
  input wire logic [2:0] WEEKDAY_I,
  input wire logic SEC_TICK_O,
  input wire logic CLK32K_O,
  input wire logic ALARM_W_O,
  input wire logic ALARM_D_O,
  input wire logic IRQ_O
);
  import rta_pkg::*;
  logic [7:0] sh [64];
  logic [15:0] c32;
  logic k_q, bad, wk_m, dy_m;
  function automatic logic [7:0] msk(input logic [5:0] i);
    case (i)
      IDX_TRIM: return 8'hFF;
      IDX_WMIN, IDX_DMIN: return MINUTE_MASK;
      IDX_WHOUR, IDX_DHOUR: return HOUR_MASK;
      IDX_WDAYS: return DAYS_MASK;
      IDX_IRQ_MASK: return IRQ_MASK_BITS;
      default: return 8'h00;
    endcase
  endfunction
  // ****************************************
  // Shadow registers rebuilt from bus writes
  // ****************************************
  assign bad = PADDR_I[1:0] != 2'h0 || (msk(PADDR_I[7:2]) == 8'h00 && PADDR_I[7:2] != IDX_IRQ_STATUS);
  assign wk_m = MINUTE_I == sh[IDX_WMIN][6:0] && HOUR_I == sh[IDX_WHOUR][5:0] && sh[IDX_WDAYS][WEEKDAY_I];
  assign dy_m = MINUTE_I == sh[IDX_DMIN][6:0] && HOUR_I == sh[IDX_DHOUR][5:0];
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      for (int i = 0; i < 64; i++) sh[i] <= 8'h00;
    end else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0] && !bad) begin
      sh[PADDR_I[7:2]] <= PWDATA_I[7:0] & msk(PADDR_I[7:2]);
    end
  end
  // First half period after reset may be one longer, so the bound allows it
  always_ff @(posedge CLK_I) begin
    k_q <= CLK32K_O;
    if (SRST_I || CLK32K_O != k_q) c32 <= 16'h0000;
    else c32 <= c32 + 16'h0001;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  property p_ready_lat; PSEL_I && !PENABLE_I |-> ##2 PREADY_O; endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("pready late");
  property p_ready_pulse; PREADY_O |-> PSEL_I && PENABLE_I ##1 !PREADY_O; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready not a single access pulse");
  property p_slverr; PREADY_O |-> PSLVERR_O == bad; endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong for address");
  property p_rd; PREADY_O && !PWRITE_I && !bad && PADDR_I[7:2] != IDX_IRQ_STATUS |-> PRDATA_O == {24'h0, sh[PADDR_I[7:2]]};
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  property p_daily; !$past(SRST_I) |-> ALARM_D_O == $past(dy_m); endproperty
  a_daily: assert property (p_daily) else $error("daily alarm wrong");
  property p_weekly; !$past(SRST_I) |-> ALARM_W_O == $past(wk_m); endproperty
  a_weekly: assert property (p_weekly) else $error("weekly alarm wrong");
  property p_irq_rise; $rose(ALARM_D_O) && sh[IDX_IRQ_MASK][IRQ_DAILY] |-> IRQ_O; endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq missing on daily alarm");
  property p_irq_mask; IRQ_O |-> $past(sh[IDX_IRQ_MASK]) != 8'h00; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all sources masked");
  property p_clk32; c32 <= HALF_DIV; endproperty
  a_clk32: assert property (p_clk32) else $error("clock output half period too long");
  cover property (ALARM_W_O);
  cover property (ALARM_D_O && IRQ_O);
  cover property (SEC_TICK_O);
endmodule
bind rta_trim_alarm rta_trim_alarm_monitor #(.HALF_DIV(HALF_DIV)) u_mon (.*);

// file: tb/rta_time_src.sv
// Seconds counter model that feeds the trim logic
`timescale 1ns/1ps
module rta_time_src (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  output logic [6:0] seconds_o
);
  // Starts at 59 so the first tick lands on second 00, an adjusted second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seconds_o <= 7'h59;
    end else if (tick_i) begin
      seconds_o <= (seconds_o == 7'h59) ? 7'h00 : (seconds_o[3:0] == 4'h9) ? {seconds_o[6:4] + 3'h1, 4'h0} :
                   seconds_o + 7'h01;
    end
  end
endmodule

// file: tb/test_rta_trim_alarm.sv
// Self-checking bench for the trim and alarm register block
`timescale 1ns/1ps
module test_rta_trim_alarm;
  import rta_pkg::*;
  // Smallest divider keeps one second near 65536 cycles
  localparam int unsigned HD = 1;
  logic clk, srst, psel, pen, pwr, pready, pslverr, tick, k32, alw, ald, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [6:0] sec, mnt;
  logic [5:0] hr;
  logic [2:0] wd;
  logic [31:0] q_rd [$];
  logic [31:0] q_sec [$];
  logic [7:0] amap [6] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30};
  logic [7:0] mmask [6] = '{8'hFF, MINUTE_MASK, HOUR_MASK, DAYS_MASK, MINUTE_MASK, HOUR_MASK};
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t_last = 0;
  rta_trim_alarm #(.HALF_DIV(HD)) DUT (.CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready),
    .PRDATA_O(prdata), .PSLVERR_O(pslverr), .SECONDS_I(sec), .MINUTE_I(mnt), .HOUR_I(hr),
    .WEEKDAY_I(wd), .SEC_TICK_O(tick), .CLK32K_O(k32), .ALARM_W_O(alw), .ALARM_D_O(ald), .IRQ_O(irq));
  rta_time_src u_src (.clk_i(clk), .rst_i(srst), .tick_i(tick), .seconds_o(sec));
  // ****************************************
  // Clock, checking tasks and result watcher
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) q_rd.push_back(e);
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic at(input logic [6:0] m, input logic [5:0] h, input logic [2:0] w);
    mnt <= m;
    hr <= h;
    wd <= w;
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pready === 1'b1 && pwr === 1'b0) chk(prdata, q_rd.pop_front());
    if (tick === 1'b1) begin
      if (t_last > 0 && q_sec.size() > 0) chk(32'(cyc - t_last), q_sec.pop_front());
      t_last = cyc;
    end
  end
  initial begin
    repeat (150000) @(posedge clk);
    errors++;
    print_verdict();
  end
  initial begin
    srst = 1'b1;
    {psel, pen, pwr} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    mnt = 7'h7F;
    hr = 6'h3F;
    wd = 3'h7;
    r = $urandom(32'h51d1);
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (amap[i]) apb(1'b0, amap[i], 32'h0, 32'h0);
    foreach (amap[i]) begin
      r = $urandom();
      apb(1'b1, amap[i], r, 32'h0);
      apb(1'b0, amap[i], 32'h0, {24'h0, r[7:0] & mmask[i]});
    end
    apb(1'b0, 8'h3C, 32'h0, 32'h0);
    apb(1'b0, 8'h21, 32'h0, 32'h0);
    // Period select one, value minus two: only second 00 shortens
    apb(1'b1, 8'h1C, 32'h0000_00FE, 32'h0);
    q_sec.push_back(2 * HD * 32764);
    // Only existing times go into the alarm registers
    apb(1'b1, 8'h20, 32'h0000_0045, 32'h0);
    pstrb <= 4'hE;
    apb(1'b1, 8'h20, 32'h0000_0000, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, 8'h20, 32'h0, 32'h0000_0045);
    apb(1'b1, 8'h24, 32'h0000_0012, 32'h0);
    apb(1'b1, 8'h2C, 32'h0000_0030, 32'h0);
    apb(1'b1, 8'h30, 32'h0000_0032, 32'h0);
    apb(1'b1, 8'h44, 32'h0000_0003, 32'h0);
    for (int d = 0; d < 8; d++) begin
      apb(1'b1, 8'h28, 32'(d < 7 ? 1 << d : 0), 32'h0);
      for (int w = 0; w < 7; w++) begin
        at(7'h45, 6'h12, 3'(w));
        chk(32'(alw), 32'(d == w));
      end
    end
    chk(32'(irq), 32'h1);
    apb(1'b0, 8'h40, 32'h0, 32'h0000_0001);
    at(7'h7F, 6'h3F, 3'h7);
    chk(32'(irq), 32'h0);
    at(7'h30, 6'h32, 3'h0);
    chk(32'(ald), 32'h1);
    chk(32'(irq), 32'h1);
    at(7'h30, 6'h12, 3'h0);
    chk(32'(ald), 32'h0);
    chk(32'(irq), 32'h1);
    apb(1'b1, 8'h44, 32'h0000_0001, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    apb(1'b0, 8'h40, 32'h0, 32'h0000_0002);
    while (q_sec.size() > 0) @(posedge clk);
    print_verdict();
  end
endmodule
